/* File: inc/dsrb_cfg.svh */
// register indices, status bit positions and answer codes of the drive status bank
`ifndef DSRB_CFG_SVH
`define DSRB_CFG_SVH

`define DSRB_IDX_STATUS 16'h0000
`define DSRB_IDX_SPEED 16'h0001
`define DSRB_IDX_POS_HI 16'h0002
`define DSRB_IDX_POS_LO 16'h0003
`define DSRB_IDX_TORQUE 16'h0004
`define DSRB_IDX_PEAK 16'h0005
`define DSRB_IDX_ULOGIC 16'h0006
`define DSRB_IDX_UDRIVE 16'h0007
`define DSRB_IDX_TEMP 16'h0008
`define DSRB_IDX_VALID 16'h0009
`define DSRB_IDX_LIMIT 16'h0100

`define DSRB_SW_TARGET 0
`define DSRB_SW_DRAG 1
`define DSRB_SW_RSV2 2
`define DSRB_SW_RSV3 3
`define DSRB_SW_MPOWER 4
`define DSRB_SW_ABORT 5
`define DSRB_SW_RUNNING 6
`define DSRB_SW_OVERTEMP 7
`define DSRB_SW_REVERSE 8
`define DSRB_SW_STORE 9
`define DSRB_SW_BLOCKED 10
`define DSRB_SW_MANUAL 11
`define DSRB_SW_BADTGT 12
`define DSRB_SW_PLOST 13
`define DSRB_SW_POSLIM 14
`define DSRB_SW_NEGLIM 15

`define DSRB_VALID_RST 1'b1
`define DSRB_EXC_NONE 8'h00
`define DSRB_EXC_ADDR 8'h02
`define DSRB_EXC_FAIL 8'h04

`endif

/* File: inc/dsrb_pkg.sv */
// state types of the drive status bank
`default_nettype none

package dsrb_pkg;

  typedef enum {
    DSRB_ACCEPT,
    DSRB_BAD_ADDR,
    DSRB_PAIR_FAIL
  } dsrb_verdict_t;

  typedef struct packed {
    logic [15:0] word;
  } dsrb_sw_state_t;

  typedef struct packed {
    logic [15:0] peak;
  } dsrb_pk_state_t;

  typedef struct packed {
    logic [15:0] speed;
    logic [15:0] torque;
    logic [15:0] ulogic;
    logic [15:0] udrive;
    logic [15:0] temp;
    logic [31:0] pos;
    logic [15:0] hi_latch;
    logic hi_pending;
    logic consistent;
    logic rsp_valid;
    logic rsp_exc;
    logic [7:0] rsp_code;
    logic [15:0] rsp_data;
    logic reref;
  } dsrb_top_state_t;

endpackage

`default_nettype wire

/* File: rtl/dsrb_status_word.sv */
// assembles the motion and fault status word from the drive's flag lines
`timescale 1ns/1ps
`default_nettype none
`include "dsrb_cfg.svh"

module dsrb_status_word
  import dsrb_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic target_reached,
  input wire logic drag_error,
  input wire logic motor_power,
  input wire logic run_aborted,
  input wire logic drive_running,
  input wire logic over_temp,
  input wire logic reverse_motion,
  input wire logic store_fault,
  input wire logic run_blocked,
  input wire logic manual_shift,
  input wire logic bad_target,
  input wire logic power_was_lost,
  input wire logic pos_limit,
  input wire logic neg_limit,
  output logic [15:0] word
);

  dsrb_sw_state_t st;
  dsrb_sw_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.word = 16'h0000;
    next_st.word[`DSRB_SW_TARGET] = target_reached;
    next_st.word[`DSRB_SW_DRAG] = drag_error;
    next_st.word[`DSRB_SW_MPOWER] = motor_power;
    next_st.word[`DSRB_SW_ABORT] = run_aborted;
    next_st.word[`DSRB_SW_RUNNING] = drive_running;
    next_st.word[`DSRB_SW_OVERTEMP] = over_temp;
    next_st.word[`DSRB_SW_REVERSE] = reverse_motion;
    next_st.word[`DSRB_SW_STORE] = store_fault;
    next_st.word[`DSRB_SW_BLOCKED] = run_blocked;
    next_st.word[`DSRB_SW_MANUAL] = manual_shift;
    next_st.word[`DSRB_SW_BADTGT] = bad_target;
    next_st.word[`DSRB_SW_PLOST] = power_was_lost;
    next_st.word[`DSRB_SW_POSLIM] = pos_limit;
    next_st.word[`DSRB_SW_NEGLIM] = neg_limit;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign word = st.word;

  reserved_zero_a: assert property (@(posedge clk) disable iff (srst)
    word[`DSRB_SW_RSV3:`DSRB_SW_RSV2] == 2'h0)
    else $error("reserved status bits not zero");

  limit_bits_a: assert property (@(posedge clk) disable iff (srst)
    (pos_limit && neg_limit) |=> (word[`DSRB_SW_NEGLIM:`DSRB_SW_POSLIM] == 2'h3))
    else $error("range limit bits not reported");

endmodule
`default_nettype wire

/* File: rtl/dsrb_peak_torque.sv */
// peak torque of the latest run, tracked only inside the measuring window
`timescale 1ns/1ps
`default_nettype none

module dsrb_peak_torque
  import dsrb_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic run_start,
  input wire logic torque_window,
  input wire logic [15:0] torque,
  output logic [15:0] peak
);

  dsrb_pk_state_t st;
  dsrb_pk_state_t next_st;

  always_comb begin
    next_st = st;
    // start-up and braking lie outside the window and never count
    if (run_start) begin
      next_st.peak = torque_window ? torque : 16'h0000;
    end else if (torque_window && (torque > st.peak)) begin
      next_st.peak = torque;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign peak = st.peak;

  peak_tracks_a: assert property (@(posedge clk) disable iff (srst)
    (torque_window && !run_start) |=> (peak >= $past(torque)))
    else $error("peak below windowed torque");

  peak_frozen_a: assert property (@(posedge clk) disable iff (srst)
    (!torque_window && !run_start) |=> $stable(peak))
    else $error("peak moved outside window");

endmodule
`default_nettype wire

/* File: rtl/dsrb_top.sv */
// drive status register bank: holding registers 0 to 9 behind the register request port
//
// Summary of operation
// - Index 0 holds the status word with target, drag, motor power, abort, running in bits 0,1,4,5,6 and bits 2,3 zero.
// - Status bits 7 to 11 flag over-temperature, reverse motion, store or encoder fault, blocked run and manual shift.
// - Status bits 12 to 15 flag bad target, lost motor power, positive limit and negative limit.
// - The signed 32-bit position reads with bytes 3-2 at index 2 and bytes 1-0 at index 3.
// - Writing the position pair re-references the present position to the written value with no motion.
// - Index 5 reads the peak torque of the latest run, ignoring start-up and braking.
// - Index 6 reads the logic supply voltage in tenths of a volt.
// - Index 7 reads the drive supply voltage in tenths of a volt.
// - Index 8 reads the internal temperature as signed whole degrees.
// - Index 9 reads 1 when the position is consistent, 0 when not, and is 1 after reset.
// - The consistency register exists only in single-turn builds.
// - The high word is written first and the 32-bit value changes only on the low-word write.
// - A write to another register between high and low word makes the low-word write fail.
`timescale 1ns/1ps
`default_nettype none
`include "dsrb_cfg.svh"

module dsrb_top
  import dsrb_pkg::*;
#(
  parameter int POS_STEP_W = 16,
  parameter bit SINGLE_TURN = 1'b1
) (
  input wire logic clk,
  input wire logic srst,
  // register requests from the frame decoder
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [15:0] holding_register_index,
  input wire logic [15:0] req_wdata,
  output logic rsp_valid,
  output logic rsp_exception,
  output logic [7:0] rsp_code,
  output logic [15:0] rsp_rdata,
  // status flags from the motion controller
  input wire logic target_reached,
  input wire logic drag_error,
  input wire logic motor_power,
  input wire logic run_aborted,
  input wire logic drive_running,
  input wire logic over_temp,
  input wire logic reverse_motion,
  input wire logic store_fault,
  input wire logic run_blocked,
  input wire logic manual_shift,
  input wire logic bad_target,
  input wire logic power_was_lost,
  input wire logic pos_limit,
  input wire logic neg_limit,
  // measured values
  input wire logic [15:0] speed_rpm,
  input wire logic [15:0] torque_cnm,
  input wire logic run_start,
  input wire logic torque_window,
  input wire logic [15:0] logic_supply_dv,
  input wire logic [15:0] drive_supply_dv,
  input wire logic [15:0] temperature_c,
  // position tracking
  input wire logic pos_step_valid,
  input wire logic [POS_STEP_W-1:0] pos_step,
  input wire logic consistency_lost,
  input wire logic consistency_regained,
  output logic [31:0] position_value,
  output logic position_rereferenced
);

  ////////////////////////////////////////////////////////////////////////////////
  // parameter checks

  if ((POS_STEP_W < 1) || (POS_STEP_W > 31)) begin : g_bad_step
    $error("POS_STEP_W must lie in 1..31");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sub-blocks

  logic [15:0] status_word;
  logic [15:0] peak_torque;

  dsrb_status_word u_status (
    .clk(clk),
    .srst(srst),
    .target_reached(target_reached),
    .drag_error(drag_error),
    .motor_power(motor_power),
    .run_aborted(run_aborted),
    .drive_running(drive_running),
    .over_temp(over_temp),
    .reverse_motion(reverse_motion),
    .store_fault(store_fault),
    .run_blocked(run_blocked),
    .manual_shift(manual_shift),
    .bad_target(bad_target),
    .power_was_lost(power_was_lost),
    .pos_limit(pos_limit),
    .neg_limit(neg_limit),
    .word(status_word)
  );

  dsrb_peak_torque u_peak (
    .clk(clk),
    .srst(srst),
    .run_start(run_start),
    .torque_window(torque_window),
    .torque(torque_cnm),
    .peak(peak_torque)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // state

  dsrb_top_state_t st;
  dsrb_top_state_t next_st;

  logic [31:0] step_ext;
  logic is_hi;
  logic is_lo;
  logic in_bank;
  logic out_of_range;

  assign step_ext = {{(32 - POS_STEP_W){pos_step[POS_STEP_W-1]}}, pos_step};
  assign is_hi = (holding_register_index == `DSRB_IDX_POS_HI);
  assign is_lo = (holding_register_index == `DSRB_IDX_POS_LO);
  assign out_of_range = (holding_register_index >= `DSRB_IDX_LIMIT);
  // multi-turn builds see index 9 as a reserved slot
  assign in_bank = (holding_register_index < `DSRB_IDX_VALID) ||
                   ((holding_register_index == `DSRB_IDX_VALID) && SINGLE_TURN);

  function automatic logic [15:0] read_mux(input logic [15:0] idx,
                                           input dsrb_top_state_t s,
                                           input logic [15:0] sw,
                                           input logic [15:0] pk);
    logic [15:0] v;
    v = 16'h0000;
    // reserved slots below the range limit read zero
    unique case (idx)
      `DSRB_IDX_STATUS: v = sw;
      `DSRB_IDX_SPEED: v = s.speed;
      `DSRB_IDX_POS_HI: v = s.pos[31:16];
      `DSRB_IDX_POS_LO: v = s.pos[15:0];
      `DSRB_IDX_TORQUE: v = s.torque;
      `DSRB_IDX_PEAK: v = pk;
      `DSRB_IDX_ULOGIC: v = s.ulogic;
      `DSRB_IDX_UDRIVE: v = s.udrive;
      `DSRB_IDX_TEMP: v = s.temp;
      `DSRB_IDX_VALID: v = SINGLE_TURN ? {15'h0, s.consistent} : 16'h0000;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    dsrb_verdict_t verdict;
    verdict = DSRB_ACCEPT;
    next_st = st;
    next_st.speed = speed_rpm;
    next_st.torque = torque_cnm;
    next_st.ulogic = logic_supply_dv;
    next_st.udrive = drive_supply_dv;
    next_st.temp = temperature_c;
    next_st.rsp_valid = 1'b0;
    next_st.reref = 1'b0;
    // a loss seen together with a regain leaves the position flagged inconsistent
    if (consistency_lost) begin
      next_st.consistent = 1'b0;
    end else if (consistency_regained) begin
      next_st.consistent = 1'b1;
    end
    if (pos_step_valid) begin
      next_st.pos = st.pos + step_ext;
    end
    if (req_valid) begin
      next_st.rsp_valid = 1'b1;
      next_st.rsp_data = 16'h0000;
      if (out_of_range) begin
        verdict = DSRB_BAD_ADDR;
        if (req_write) begin
          next_st.hi_pending = 1'b0;
        end
      end else if (!req_write) begin
        next_st.rsp_data = read_mux(holding_register_index, st, status_word,
                                    peak_torque);
      end else if (is_hi) begin
        next_st.hi_latch = req_wdata;
        next_st.hi_pending = 1'b1;
      end else if (is_lo) begin
        if (st.hi_pending) begin
          // the re-reference overrides a step taken in the same cycle
          next_st.pos = {st.hi_latch, req_wdata};
          next_st.hi_pending = 1'b0;
          next_st.reref = 1'b1;
        end else begin
          verdict = DSRB_PAIR_FAIL;
        end
      end else if (in_bank) begin
        verdict = DSRB_BAD_ADDR;
        next_st.hi_pending = 1'b0;
      end else begin
        next_st.hi_pending = 1'b0;
      end
      unique case (verdict)
        DSRB_ACCEPT: begin
          next_st.rsp_exc = 1'b0;
          next_st.rsp_code = `DSRB_EXC_NONE;
        end
        DSRB_BAD_ADDR: begin
          next_st.rsp_exc = 1'b1;
          next_st.rsp_code = `DSRB_EXC_ADDR;
        end
        DSRB_PAIR_FAIL: begin
          next_st.rsp_exc = 1'b1;
          next_st.rsp_code = `DSRB_EXC_FAIL;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
      st.consistent <= `DSRB_VALID_RST;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign rsp_valid = st.rsp_valid;
  assign rsp_exception = st.rsp_exc;
  assign rsp_code = st.rsp_code;
  assign rsp_rdata = st.rsp_data;
  assign position_value = st.pos;
  assign position_rereferenced = st.reref;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  answer_timing_a: assert property (@(posedge clk) disable iff (srst)
    req_valid |=> rsp_valid)
    else $error("request not answered next cycle");

  no_spurious_a: assert property (@(posedge clk) disable iff (srst)
    !req_valid |=> !rsp_valid)
    else $error("answer without request");

  status_read_a: assert property (@(posedge clk) disable iff (srst)
    (req_valid && !req_write && (holding_register_index == `DSRB_IDX_STATUS))
    |=> (rsp_rdata == $past(status_word)) && !rsp_exception)
    else $error("status word read wrong");

  pos_high_read_a: assert property (@(posedge clk) disable iff (srst)
    (req_valid && !req_write && is_hi) |=> (rsp_rdata == $past(st.pos[31:16])))
    else $error("position high half read wrong");

  reref_value_a: assert property (@(posedge clk) disable iff (srst)
    (req_valid && req_write && is_lo && st.hi_pending)
    |=> (position_value == {$past(st.hi_latch), $past(req_wdata)}) &&
        position_rereferenced && !rsp_exception)
    else $error("re-reference did not load written pair");

  high_no_effect_a: assert property (@(posedge clk) disable iff (srst)
    (req_valid && req_write && is_hi && !pos_step_valid) |=> $stable(position_value))
    else $error("high word write moved position");

  pair_break_a: assert property (@(posedge clk) disable iff (srst)
    (req_valid && req_write && is_hi) ##1
    (req_valid && req_write && !is_hi && !is_lo) ##1
    (req_valid && req_write && is_lo)
    |=> rsp_exception && (rsp_code == `DSRB_EXC_FAIL) && !position_rereferenced)
    else $error("broken pair not rejected");

  ro_write_a: assert property (@(posedge clk) disable iff (srst)
    (req_valid && req_write && in_bank && !is_hi && !is_lo)
    |=> rsp_exception && (rsp_code == `DSRB_EXC_ADDR))
    else $error("write to read-only register accepted");

  range_limit_a: assert property (@(posedge clk) disable iff (srst)
    (req_valid && out_of_range) |=> rsp_exception && (rsp_code == `DSRB_EXC_ADDR))
    else $error("index beyond limit not rejected");

  valid_after_reset_a: assert property (@(posedge clk)
    srst |=> (st.consistent == 1'b1))
    else $error("consistency flag not set by reset");

  valid_multi_a: assert property (@(posedge clk) disable iff (srst)
    (!SINGLE_TURN && req_valid && !req_write &&
     (holding_register_index == `DSRB_IDX_VALID)) |=> (rsp_rdata == 16'h0000))
    else $error("multi-turn build exposes consistency flag");

  supply_read_a: assert property (@(posedge clk) disable iff (srst)
    (req_valid && !req_write && (holding_register_index == `DSRB_IDX_ULOGIC))
    |=> (rsp_rdata == $past(logic_supply_dv, 2)))
    else $error("logic supply read wrong");

  drive_read_a: assert property (@(posedge clk) disable iff (srst)
    (req_valid && !req_write && (holding_register_index == `DSRB_IDX_UDRIVE))
    |=> (rsp_rdata == $past(drive_supply_dv, 2)))
    else $error("drive supply read wrong");

  temp_read_a: assert property (@(posedge clk) disable iff (srst)
    (req_valid && !req_write && (holding_register_index == `DSRB_IDX_TEMP))
    |=> (rsp_rdata == $past(temperature_c, 2)))
    else $error("temperature read wrong");

  pair_reject_a: assert property (@(posedge clk) disable iff (srst)
    (req_valid && req_write && is_lo && !st.hi_pending && !pos_step_valid)
    |=> rsp_exception && (rsp_code == `DSRB_EXC_FAIL) && !position_rereferenced &&
        $stable(position_value))
    else $error("low word without pending high word accepted");

  pending_clear_a: assert property (@(posedge clk) disable iff (srst)
    (req_valid && req_write && !is_hi && !is_lo) |=> !st.hi_pending)
    else $error("other write left high word pending");

  pending_set_a: assert property (@(posedge clk) disable iff (srst)
    (req_valid && req_write && is_hi)
    |=> st.hi_pending && (st.hi_latch == $past(req_wdata)))
    else $error("high word not latched");

  read_keeps_pair_a: assert property (@(posedge clk) disable iff (srst)
    (req_valid && !req_write) |=> (st.hi_pending == $past(st.hi_pending)))
    else $error("read changed pending high word");

  pos_low_read_a: assert property (@(posedge clk) disable iff (srst)
    (req_valid && !req_write && is_lo) |=> (rsp_rdata == $past(st.pos[15:0])))
    else $error("position low half read wrong");

  speed_read_a: assert property (@(posedge clk) disable iff (srst)
    (req_valid && !req_write && (holding_register_index == `DSRB_IDX_SPEED))
    |=> (rsp_rdata == $past(speed_rpm, 2)))
    else $error("speed read wrong");

  torque_read_a: assert property (@(posedge clk) disable iff (srst)
    (req_valid && !req_write && (holding_register_index == `DSRB_IDX_TORQUE))
    |=> (rsp_rdata == $past(torque_cnm, 2)))
    else $error("torque read wrong");

  peak_read_a: assert property (@(posedge clk) disable iff (srst)
    (req_valid && !req_write && (holding_register_index == `DSRB_IDX_PEAK))
    |=> (rsp_rdata == $past(peak_torque)))
    else $error("peak torque read wrong");

  reserved_read_a: assert property (@(posedge clk) disable iff (srst)
    (req_valid && !req_write && !out_of_range &&
     (holding_register_index > `DSRB_IDX_VALID))
    |=> (rsp_rdata == 16'h0000) && !rsp_exception)
    else $error("reserved register read not zero");

endmodule
`default_nettype wire

/* File: verification/dsrb_master_model.sv */
// bus master model that issues single register requests to the status bank
`timescale 1ns/1ps
`default_nettype none

module dsrb_master_model (
  input wire logic clk,
  output logic req_valid,
  output logic req_write,
  output logic [15:0] holding_register_index,
  output logic [15:0] req_wdata,
  input wire logic rsp_valid,
  input wire logic rsp_exception,
  input wire logic [7:0] rsp_code,
  input wire logic [15:0] rsp_rdata
);
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    holding_register_index = 16'hFFFF;
    req_wdata = 16'hFFFF;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // reads by register index stand for the read-holding function
  // paired values are sent high word first, as the caller orders them
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [15:0] d,
      output logic [7:0] code, output logic exc, output logic [15:0] rdata,
      output logic ans);
    ans = 1'b0;
    code = 8'hFF;
    exc = 1'b1;
    rdata = 16'hFFFF;
    req_valid = 1'b1;
    req_write = wr;
    holding_register_index = idx;
    req_wdata = d;
    @(posedge clk);
    #1;
    // released lines show the inverse so a stale value never passes as current
    req_valid = 1'b0;
    req_write = ~wr;
    holding_register_index = ~idx;
    req_wdata = ~d;
    for (int n = 0; n < 4 && !ans; n++) begin
      if (rsp_valid === 1'b1) begin
        ans = 1'b1;
        code = rsp_code;
        exc = rsp_exception;
        rdata = rsp_rdata;
      end else begin
        @(posedge clk);
        #1;
      end
    end
    // one idle cycle so the strobe is never lowered and raised in one step
    @(posedge clk);
    #1;
  endtask
endmodule

`default_nettype wire

/* File: verification/drive_status_register_bank_test.sv */
// self-checking bench for the drive status register bank
`timescale 1ns/1ps
`default_nettype none

module drive_status_register_bank_test;
  logic clk;
  logic srst;
  logic req_valid, req_write, rsp_valid, rsp_exception, position_rereferenced;
  logic [15:0] holding_register_index, req_wdata, rsp_rdata;
  logic [7:0] rsp_code;
  logic [13:0] flags;
  logic [15:0] speed, torque, ulog, udrv, temp, pos_step;
  logic run_start, torque_window, pos_step_valid, cons_lost, cons_regained;
  logic [31:0] position_value;
  int bad_count = 0;
  int num_checks = 0;
  int reref_count = 0;

  dsrb_top dut (
    .clk(clk), .srst(srst),
    .req_valid(req_valid), .req_write(req_write),
    .holding_register_index(holding_register_index), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_exception(rsp_exception), .rsp_code(rsp_code),
    .rsp_rdata(rsp_rdata),
    .target_reached(flags[0]), .drag_error(flags[1]), .motor_power(flags[2]),
    .run_aborted(flags[3]), .drive_running(flags[4]), .over_temp(flags[5]),
    .reverse_motion(flags[6]), .store_fault(flags[7]), .run_blocked(flags[8]),
    .manual_shift(flags[9]), .bad_target(flags[10]), .power_was_lost(flags[11]),
    .pos_limit(flags[12]), .neg_limit(flags[13]),
    .speed_rpm(speed), .torque_cnm(torque), .run_start(run_start),
    .torque_window(torque_window), .logic_supply_dv(ulog), .drive_supply_dv(udrv),
    .temperature_c(temp), .pos_step_valid(pos_step_valid), .pos_step(pos_step),
    .consistency_lost(cons_lost), .consistency_regained(cons_regained),
    .position_value(position_value), .position_rereferenced(position_rereferenced)
  );

  dsrb_master_model mst (
    .clk(clk), .req_valid(req_valid), .req_write(req_write),
    .holding_register_index(holding_register_index), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_exception(rsp_exception), .rsp_code(rsp_code),
    .rsp_rdata(rsp_rdata)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (position_rereferenced === 1'b1) begin
      reref_count++;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // writes answer with zero data, so one expectation covers both kinds
  task automatic acc(input logic wr, input logic [15:0] idx, input logic [15:0] d,
      input logic [7:0] exp_code, input logic [15:0] exp_data);
    logic [7:0] code;
    logic exc;
    logic [15:0] rd;
    logic ans;
    mst.xfer(wr, idx, d, code, exc, rd, ans);
    if (ans !== 1'b1) begin
      bad_count++;
      $display("[FAIL] answer expected 1 seen 0");
      end_of_test();
    end
    chk("answer code", {24'h0, exp_code}, {24'h0, code});
    chk("exception flag", {31'h0, exp_code != 8'h00}, {31'h0, exc});
    chk("answer data", {16'h0, exp_data}, {16'h0, rd});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    {flags, speed, torque, ulog, udrv, temp, pos_step} = '0;
    {run_start, torque_window, pos_step_valid, cons_lost, cons_regained} = '0;
    cyc(5);
    srst = 1'b0;
    cyc(2);
    acc(1'b0, 16'h0009, 16'h0000, 8'h00, 16'h0001);
    acc(1'b0, 16'h0005, 16'h0000, 8'h00, 16'h0000);
    // walking one across every flag line, then all at once
    for (int k = 0; k < 14; k++) begin
      flags = 14'h0001 << k;
      cyc(3);
      acc(1'b0, 16'h0000, 16'h0000, 8'h00, {flags[13:2], 2'b00, flags[1:0]});
    end
    flags = 14'h3FFF;
    cyc(3);
    acc(1'b0, 16'h0000, 16'h0000, 8'h00, 16'hFFF3);
    speed = 16'hFF38;
    torque = 16'h04D2;
    ulog = 16'h00F0;
    udrv = 16'h00EF;
    temp = 16'hFFF6;
    cyc(3);
    acc(1'b0, 16'h0001, 16'h0000, 8'h00, 16'hFF38);
    acc(1'b0, 16'h0004, 16'h0000, 8'h00, 16'h04D2);
    acc(1'b0, 16'h0006, 16'h0000, 8'h00, 16'h00F0);
    acc(1'b0, 16'h0007, 16'h0000, 8'h00, 16'h00EF);
    acc(1'b0, 16'h0008, 16'h0000, 8'h00, 16'hFFF6);
    // a step up and a step down leave the position at 90
    pos_step = 16'h0064;
    pos_step_valid = 1'b1;
    cyc(1);
    pos_step = 16'hFFF6;
    cyc(1);
    pos_step_valid = 1'b0;
    cyc(2);
    acc(1'b0, 16'h0002, 16'h0000, 8'h00, 16'h0000);
    acc(1'b0, 16'h0003, 16'h0000, 8'h00, 16'h005A);
    acc(1'b1, 16'h0002, 16'hFFFE, 8'h00, 16'h0000);
    acc(1'b1, 16'h0003, 16'h1234, 8'h00, 16'h0000);
    chk("position", 32'hFFFE1234, position_value);
    chk("rereference pulses", 32'h1, reref_count);
    acc(1'b0, 16'h0002, 16'h0000, 8'h00, 16'hFFFE);
    acc(1'b0, 16'h0003, 16'h0000, 8'h00, 16'h1234);
    acc(1'b1, 16'h0003, 16'h0001, 8'h04, 16'h0000);
    acc(1'b1, 16'h0002, 16'h0000, 8'h00, 16'h0000);
    acc(1'b1, 16'h0005, 16'h0000, 8'h02, 16'h0000);
    acc(1'b1, 16'h0003, 16'h0007, 8'h04, 16'h0000);
    chk("position", 32'hFFFE1234, position_value);
    chk("rereference pulses", 32'h1, reref_count);
    // a read between the halves must not break the pair
    acc(1'b1, 16'h0002, 16'h0001, 8'h00, 16'h0000);
    acc(1'b0, 16'h000A, 16'h0000, 8'h00, 16'h0000);
    acc(1'b1, 16'h0003, 16'h0002, 8'h00, 16'h0000);
    chk("position", 32'h00010002, position_value);
    chk("rereference pulses", 32'h2, reref_count);
    acc(1'b0, 16'h0100, 16'h0000, 8'h02, 16'h0000);
    cons_lost = 1'b1;
    cyc(1);
    cons_lost = 1'b0;
    cyc(2);
    acc(1'b0, 16'h0009, 16'h0000, 8'h00, 16'h0000);
    cons_regained = 1'b1;
    cyc(1);
    cons_regained = 1'b0;
    cyc(2);
    acc(1'b0, 16'h0009, 16'h0000, 8'h00, 16'h0001);
    // start-up and braking torque lie outside the window and must not count
    run_start = 1'b1;
    cyc(1);
    run_start = 1'b0;
    torque_window = 1'b1;
    torque = 16'h0064;
    cyc(1);
    torque = 16'h012C;
    cyc(1);
    torque = 16'h00C8;
    cyc(1);
    torque_window = 1'b0;
    torque = 16'h0384;
    cyc(2);
    acc(1'b0, 16'h0005, 16'h0000, 8'h00, 16'h012C);
    run_start = 1'b1;
    cyc(1);
    run_start = 1'b0;
    cyc(2);
    acc(1'b0, 16'h0005, 16'h0000, 8'h00, 16'h0000);
    // reset in mid-pair with the flag lost: all must return to reset values
    cons_lost = 1'b1;
    acc(1'b1, 16'h0002, 16'h0005, 8'h00, 16'h0000);
    cons_lost = 1'b0;
    srst = 1'b1;
    cyc(2);
    srst = 1'b0;
    cyc(2);
    chk("position after reset", 32'h0, position_value);
    acc(1'b0, 16'h0009, 16'h0000, 8'h00, 16'h0001);
    acc(1'b1, 16'h0003, 16'h0008, 8'h04, 16'h0000);
    chk("position after reset", 32'h0, position_value);
    end_of_test();
  end
endmodule

`default_nettype wire
